// >>> hdl/qlsd_channel.sv
module qlsd_channel
   import qlsd_pkg::*;
#(
   parameter int DEGLITCH = DEGLITCH_CYC,
   parameter int RETRY = RETRY_CYC
) (
   // clock and internal reset
   input wire logic core_clk,
   input wire logic clr,
   // status
   input wire logic limit_active,
   output logic tripped
);
   import qlsd_pkg::*;

   localparam int CW = $clog2(RETRY + 1);

   if (DEGLITCH < 1 || RETRY < 1 || DEGLITCH > RETRY) begin : g_bad_timing
      $error("qlsd_channel: bad timing parameters");
   end

   function automatic logic [CW-1:0] cyc(input int n);
      cyc = n[CW-1:0];
   endfunction : cyc

   qlsd_state_t state;
   logic [CW-1:0] count;

   always_ff @(posedge core_clk) begin
      if (clr) begin
         state <= QLSD_RUN;
         count <= '0;
      end else begin
         case (state)
            QLSD_RUN: begin
               count <= '0;
               if (limit_active) begin
                  state <= QLSD_COUNT;
                  count <= cyc(1);
               end
            end
            QLSD_COUNT: begin
               // any gap in the limit restarts the deglitch
               if (!limit_active) begin
                  state <= QLSD_RUN;
                  count <= '0;
               end else if (count >= cyc(DEGLITCH)) begin
                  state <= QLSD_TRIP;
                  count <= '0;
               end else begin
                  count <= count + cyc(1);
               end
            end
            QLSD_TRIP: begin
               if (count >= cyc(RETRY - 1)) begin
                  state <= QLSD_RUN;
                  count <= '0;
               end else begin
                  count <= count + cyc(1);
               end
            end
            default: begin
               state <= QLSD_RUN;
               count <= '0;
            end
         endcase
      end
   end

   assign tripped = (state == QLSD_TRIP);

   property p_trip_hold;
      @(posedge core_clk) disable iff (clr)
      $rose(tripped) |-> tripped [*8];
   endproperty
   a_trip_hold: assert property (p_trip_hold)
      else $error("trip released too early");

   property p_no_early_trip;
      @(posedge core_clk) disable iff (clr)
      !limit_active |=> !$rose(tripped);
   endproperty
   a_no_early_trip: assert property (p_no_early_trip)
      else $error("trip without sustained limit");

   // helper: length of the running trip, so the full retry can be checked
   logic [CW-1:0] hold_len;

   always_ff @(posedge core_clk) begin
      if (clr || !tripped) begin
         hold_len <= '0;
      end else begin
         hold_len <= hold_len + cyc(1);
      end
   end

   property p_retry_len;
      @(posedge core_clk) disable iff (clr)
      ($fell(tripped) && !$past(clr)) |-> hold_len == cyc(RETRY);
   endproperty
   a_retry_len: assert property (p_retry_len)
      else $error("retry interval of wrong length");
endmodule : qlsd_channel

// >>> hdl/qlsd_pkg.sv
// What this block does
// - each input switches only its own output
// - enable_n high forces every output off
// - undriven enable and reset read as low
// - limit held past deglitch trips, flags fault
// - tripped channel stays off retry time, clears
// - reset or supply loss clears overcurrent immediately
// - thermal shutdown turns all off, flags fault
// - outputs resume when temperature recovers
// - supply below threshold holds logic reset
// - supply above threshold resumes normal operation
// - reset input clears faults and timers
// - inputs ignored while reset held
// - internal power-up reset provided
// - outputs follow inputs up to 100 kHz
package qlsd_pkg;
   localparam int CLK_MHZ = 100;
   localparam int NUM_CH = 4;
   localparam int DEGLITCH_NS = 3500;
   localparam int RETRY_US = 1200;
   localparam int DEGLITCH_CYC = DEGLITCH_NS * CLK_MHZ / 1000;
   localparam int RETRY_CYC = RETRY_US * CLK_MHZ;
   localparam int POR_CYC = 16;
   localparam int PWM_MAX_KHZ = 100;

   typedef struct packed {
      logic [NUM_CH-1:0] level;
   } qlsd_chan_t;

   typedef enum logic [1:0] {
      QLSD_RUN = 2'b00,
      QLSD_COUNT = 2'b01,
      QLSD_TRIP = 2'b10
   } qlsd_state_t;
endpackage : qlsd_pkg

// >>> hdl/qlsd_top.sv
module qlsd_top
   import qlsd_pkg::*;
#(
   parameter int DEGLITCH = DEGLITCH_CYC,
   parameter int RETRY = RETRY_CYC
) (
   // clock and reset
   input wire logic core_clk,
   input wire logic rst,
   // host inputs
   input wire qlsd_pkg::qlsd_chan_t channel_input,
   input wire logic enable_n,
   // analog monitors
   input wire qlsd_pkg::qlsd_chan_t current_limit,
   input wire logic thermal_shutdown,
   input wire logic main_supply_ok,
   // outputs
   output qlsd_pkg::qlsd_chan_t channel_output,
   output logic fault_flag_o,
   output logic fault_flag_oe
);
   import qlsd_pkg::*;

   if (NUM_CH != 4 || CLK_MHZ * 1000 / PWM_MAX_KHZ < 2) begin : g_bad_cfg
      $error("qlsd_top: four channels and a fast enough clock only");
   end

   // power-up reset counter; counts up from zero only until first release
   logic [4:0] por_count = 5'h00;
   logic por_busy;
   logic int_rst;
   logic [NUM_CH-1:0] tripped;

   assign por_busy = (por_count < 5'(POR_CYC));
   // pulldowns are pad resistors; undriven pins arrive low here
   assign int_rst = rst || !main_supply_ok || por_busy;

   always_ff @(posedge core_clk) begin
      if (por_busy) begin
         por_count <= por_count + 5'h01;
      end
   end

   genvar g;
   generate
      for (g = 0; g < NUM_CH; g++) begin : g_ch
         qlsd_channel #(
            .DEGLITCH(DEGLITCH),
            .RETRY(RETRY)
         ) i_qlsd_channel (
            .core_clk(core_clk),
            .clr(int_rst),
            .limit_active(current_limit.level[g]),
            .tripped(tripped[g])
         );
      end
   endgenerate

   // registered drive; one cycle latency keeps far inside 100 kHz
   always_ff @(posedge core_clk) begin
      if (int_rst) begin
         channel_output <= '0;
      end else if (enable_n || thermal_shutdown) begin
         channel_output <= '0;
      end else begin
         // per-channel mask
         channel_output.level <= channel_input.level & ~tripped;
      end
   end

   // open drain: output always low, enable asserts the fault
   always_ff @(posedge core_clk) begin
      fault_flag_o <= 1'b0;
      if (int_rst) begin
         fault_flag_oe <= 1'b0;
      end else begin
         fault_flag_oe <= thermal_shutdown || (|tripped);
      end
   end

   property p_disable;
      @(posedge core_clk) disable iff (rst)
      enable_n |=> channel_output.level == '0;
   endproperty
   a_disable: assert property (p_disable)
      else $error("output on while disabled");

   property p_thermal;
      @(posedge core_clk) disable iff (int_rst)
      (!int_rst && thermal_shutdown)
         |=> (channel_output.level == '0) && fault_flag_oe;
   endproperty
   a_thermal: assert property (p_thermal)
      else $error("thermal shutdown not honoured");

   property p_follow;
      @(posedge core_clk) disable iff (int_rst)
      (!int_rst && !enable_n && !thermal_shutdown && tripped == '0)
         |=> channel_output.level == $past(channel_input.level);
   endproperty
   a_follow: assert property (p_follow)
      else $error("output does not follow input");

   property p_reset_off;
      @(posedge core_clk)
      rst |=> (channel_output.level == '0) && !fault_flag_oe;
   endproperty
   a_reset_off: assert property (p_reset_off)
      else $error("outputs active in reset");

   property p_undervoltage_lockout;
      @(posedge core_clk)
      !main_supply_ok |=> channel_output.level == '0;
   endproperty
   a_undervoltage_lockout: assert property (p_undervoltage_lockout)
      else $error("outputs active in lockout");

   property p_flag_release;
      @(posedge core_clk) disable iff (int_rst)
      (!thermal_shutdown && tripped == '0) |=> !fault_flag_oe;
   endproperty
   a_flag_release: assert property (p_flag_release)
      else $error("fault flag stuck");

   property p_trip_mask;
      @(posedge core_clk) disable iff (int_rst)
      !int_rst |=> (channel_output.level & $past(tripped)) == '0;
   endproperty
   a_trip_mask: assert property (p_trip_mask)
      else $error("tripped channel driven");

   property p_flag_drive;
      @(posedge core_clk) disable iff (int_rst)
      !fault_flag_o;
   endproperty
   a_flag_drive: assert property (p_flag_drive)
      else $error("open drain drives high");

   property p_trip_flag;
      @(posedge core_clk) disable iff (int_rst)
      (!int_rst && (|tripped)) |=> fault_flag_oe;
   endproperty
   a_trip_flag: assert property (p_trip_flag)
      else $error("trip without fault flag");

   property p_own_input;
      @(posedge core_clk) disable iff (int_rst)
      1'b1 |=> (channel_output.level & ~$past(channel_input.level)) == '0;
   endproperty
   a_own_input: assert property (p_own_input)
      else $error("output on without its own input");

   property p_fault_clear;
      @(posedge core_clk)
      (rst || !main_supply_ok) |=> tripped == '0;
   endproperty
   a_fault_clear: assert property (p_fault_clear)
      else $error("overcurrent fault not cleared at once");

   property p_undervoltage_lockout_flag;
      @(posedge core_clk)
      !main_supply_ok |=> !fault_flag_oe;
   endproperty
   a_undervoltage_lockout_flag: assert property (p_undervoltage_lockout_flag)
      else $error("fault flag driven in lockout");

   property p_timer_clear;
      @(posedge core_clk)
      rst |=> (tripped == '0) && !fault_flag_oe;
   endproperty
   a_timer_clear: assert property (p_timer_clear)
      else $error("reset left fault state");

   property p_por_off;
      @(posedge core_clk)
      por_busy |=> (channel_output.level == '0) && !fault_flag_oe;
   endproperty
   a_por_off: assert property (p_por_off)
      else $error("outputs active in power-up reset");

   property p_thermal_resume;
      @(posedge core_clk) disable iff (int_rst)
      ($fell(thermal_shutdown) && !int_rst && !enable_n && tripped == '0)
         |=> channel_output.level == $past(channel_input.level);
   endproperty
   a_thermal_resume: assert property (p_thermal_resume)
      else $error("no resume after thermal recovery");

   property p_supply_resume;
      @(posedge core_clk) disable iff (rst)
      ($rose(main_supply_ok) && !rst && !por_busy && !enable_n
         && !thermal_shutdown && tripped == '0)
         |=> channel_output.level == $past(channel_input.level);
   endproperty
   a_supply_resume: assert property (p_supply_resume)
      else $error("no resume after supply recovery");

   property p_thermal_release;
      @(posedge core_clk) disable iff (int_rst)
      ($fell(thermal_shutdown) && !int_rst && tripped == '0)
         |=> !fault_flag_oe;
   endproperty
   a_thermal_release: assert property (p_thermal_release)
      else $error("fault flag held after thermal recovery");

   property p_enable_restore;
      @(posedge core_clk) disable iff (int_rst)
      ($fell(enable_n) && !int_rst && !thermal_shutdown && tripped == '0)
         |=> channel_output.level == $past(channel_input.level);
   endproperty
   a_enable_restore: assert property (p_enable_restore)
      else $error("outputs not restored on enable");

   // per-channel checks: one tripped channel must not hold up the others
   for (g = 0; g < NUM_CH; g++) begin : g_ch_check
      property p_ch_follow;
         @(posedge core_clk) disable iff (int_rst)
         (!int_rst && !enable_n && !thermal_shutdown && !tripped[g])
            |=> channel_output.level[g] == $past(channel_input.level[g]);
      endproperty
      a_ch_follow: assert property (p_ch_follow)
         else $error("channel does not follow its own input");

      property p_ch_trip;
         @(posedge core_clk) disable iff (int_rst)
         (!int_rst && tripped[g])
            |=> !channel_output.level[g] && fault_flag_oe;
      endproperty
      a_ch_trip: assert property (p_ch_trip)
         else $error("tripped channel not shut down");
   end
endmodule : qlsd_top

// >>> testbench/qlsd_host.sv
module qlsd_host
   import qlsd_pkg::*;
(
   // clock
   input wire logic core_clk,
   // host pins
   output qlsd_pkg::qlsd_chan_t channel_input,
   output logic enable_n,
   output logic rst
);
   timeunit 1ns;
   timeprecision 1ns;
   initial begin
      channel_input = '0;
      enable_n = 1'b0;
      rst = 1'b1;
   end
   // pins move just after an edge, then hold until the next call
   task put(input logic [3:0] lv, input logic en_n, input logic r);
      @(posedge core_clk);
      channel_input.level <= lv;
      enable_n <= en_n;
      rst <= r;
   endtask : put
endmodule : qlsd_host

// >>> testbench/tb_qlsd_top.sv
module tb_qlsd_top;
   timeunit 1ns;
   timeprecision 1ns;
   import qlsd_pkg::*;
   localparam int DG = 5;
   localparam int RT = 40;
   // half period at the fastest modulation rate
   localparam int HOLD = 500;
   logic core_clk;
   logic rst;
   logic enable_n;
   qlsd_chan_t chan_in;
   qlsd_chan_t limit;
   qlsd_chan_t chan_out;
   logic thermal = 1'b0;
   logic supply_ok = 1'b1;
   logic fl_o;
   logic fl_oe;
   // open drain line with pull-up
   wire logic fault_n = fl_oe ? fl_o : 1'b1;
   int bad_count = 0;
   int samples_checked = 0;
   logic [15:0] seed = 16'h1B3D;
   logic [4:0] q[$];
   logic [4:0] e;
   qlsd_host i_qlsd_host(.core_clk(core_clk), .channel_input(chan_in),
      .enable_n(enable_n), .rst(rst));
   qlsd_top #(.DEGLITCH(DG), .RETRY(RT)) i_qlsd_top(.core_clk(core_clk),
      .rst(rst), .channel_input(chan_in), .enable_n(enable_n),
      .current_limit(limit), .thermal_shutdown(thermal),
      .main_supply_ok(supply_ok), .channel_output(chan_out),
      .fault_flag_o(fl_o), .fault_flag_oe(fl_oe));
   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction : lfsr
   task stop_test();
      $display("checks %0d mismatches %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : stop_test
   task cmp_out(input logic [3:0] x);
      samples_checked++;
      if (chan_out.level !== x) begin
         bad_count++;
         $display("unexpected channel_output %h %h", x, chan_out.level);
      end
   endtask : cmp_out
   task cmp_flag(input logic x);
      samples_checked++;
      if (fault_n !== x) begin
         bad_count++;
         $display("unexpected fault_flag_n %b %b", x, fault_n);
      end
   endtask : cmp_flag
   task drv(input logic [3:0] lv, input logic en, input logic r,
      input logic [3:0] lim, input logic th, input logic ok);
      i_qlsd_host.put(lv, en, r);
      limit.level <= lim;
      thermal <= th;
      supply_ok <= ok;
   endtask : drv
   task note(input int n, input logic [3:0] o, input logic f);
      repeat (n) @(posedge core_clk);
      #1 q.push_back({o, f});
   endtask : note
   // outputs are settled half a cycle after the edge
   always @(negedge core_clk) begin
      if (q.size() != 0) begin
         e = q.pop_front();
         cmp_out(e[4:1]);
         cmp_flag(e[0]);
      end
   end
   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end
   initial begin
      #100000;
      bad_count++;
      stop_test();
   end
   initial begin
      limit = '0;
      repeat (1) @(posedge core_clk);
      drv(4'hF, 0, 0, 0, 0, 1);
      note(1, 4'h0, 1);
      repeat (20) @(posedge core_clk);
      for (int k = 0; k < 4; k++) begin
         seed = lfsr(seed);
         drv(seed[3:0], 0, 0, 0, 0, 1);
         note(2, seed[3:0], 1);
         repeat (HOLD) @(posedge core_clk);
      end
      drv(4'hF, 1, 0, 0, 0, 1);
      note(2, 4'h0, 1);
      drv(4'hF, 0, 0, 0, 1, 1);
      note(2, 4'h0, 0);
      drv(4'hF, 0, 0, 0, 0, 1);
      note(2, 4'hF, 1);
      drv(4'hF, 0, 0, 4'h2, 0, 1);
      note(6, 4'hF, 1);
      note(1, 4'hD, 0);
      note(2, 4'hD, 0);
      drv(4'hF, 0, 0, 0, 0, 1);
      note(20, 4'hD, 0);
      note(16, 4'hD, 0);
      note(1, 4'hF, 1);
      note(8, 4'hF, 1);
      drv(4'hF, 0, 0, 4'h1, 0, 1);
      note(9, 4'hE, 0);
      drv(4'h5, 1, 1, 0, 0, 1);
      note(2, 4'h0, 1);
      drv(4'hA, 0, 1, 0, 0, 1);
      note(1, 4'h0, 1);
      drv(4'hF, 0, 0, 0, 0, 1);
      note(3, 4'hF, 1);
      drv(4'hF, 0, 0, 4'h4, 0, 1);
      note(9, 4'hB, 0);
      drv(4'hF, 0, 0, 0, 0, 0);
      note(2, 4'h0, 1);
      drv(4'hF, 0, 0, 0, 0, 1);
      note(3, 4'hF, 1);
      repeat (3) @(posedge core_clk);
      stop_test();
   end
endmodule : tb_qlsd_top
